// *** common/pslm_regs.vh ***
// Purpose: Constants for the strap, LED and mode control block
// Assumes: 250 MHz system clock, byte addresses on APB
// Notes: Times in ns, counts derived from the clock period
`ifndef PSLM_REGS_VH
`define PSLM_REGS_VH

`define PSLM_CLK_PERIOD_NS 4
// Reset pulse least width and strap settle/sample time
`define PSLM_RST_MIN_NS 80
`define PSLM_RST_MIN_CYC ((`PSLM_RST_MIN_NS + `PSLM_CLK_PERIOD_NS - 1) / `PSLM_CLK_PERIOD_NS)
`define PSLM_SAMPLE_NS 640
`define PSLM_SAMPLE_CYC (`PSLM_SAMPLE_NS / `PSLM_CLK_PERIOD_NS)
// Collision LED stretch time
`define PSLM_STRETCH_NS 50000000
`define PSLM_STRETCH_CYC (`PSLM_STRETCH_NS / `PSLM_CLK_PERIOD_NS)

// Register byte offsets
`define PSLM_OFF_STATUS 12'h000
`define PSLM_OFF_MASK 12'h004
`define PSLM_OFF_CONFIG 12'h008
`define PSLM_OFF_STATE 12'h00C

// Status / mask bit positions
`define PSLM_EV_LINK_UP 0
`define PSLM_EV_LINK_DOWN 1
`define PSLM_EV_COLL 2
`define PSLM_EV_DUPLEX 3
`define PSLM_EV_W 4

// Config bit positions
`define PSLM_CFG_FULL_DUPLEX 0
`define PSLM_CFG_SQE_OVR 1
`define PSLM_CFG_SQE_OVR_VAL 2
`define PSLM_CFG_RESET 3'h0

// State register field positions
`define PSLM_ST_ADDR_LSB 0
`define PSLM_ST_DONE 5
`define PSLM_ST_FULL 6
`define PSLM_ST_LINK 7
`define PSLM_ST_REPEATER 8
`define PSLM_ST_SQE 9
`define PSLM_ST_DIR_OUT 10
`define PSLM_ST_POL_LSB 11

`endif

// *** core/pslm_sync.v ***
// Purpose: Two-flop synchroniser for a bus of pin levels
// Assumes: Inputs come from outside the clk_sys domain
// Notes: First stage feeds only the second stage
`timescale 1ns/100ps
module pslm_sync #(
    parameter W = 8
) (
    clk_sys,
    rst_n,
    d,
    q
);
    input wire clk_sys;
    input wire rst_n;
    input wire [W-1:0] d;
    output reg [W-1:0] q;

    reg [W-1:0] meta_r;

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= {W{1'b0}};
            q <= {W{1'b0}};
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule // pslm_sync

// *** core/pslm_top.v ***
// Purpose: Strap sampling, LED drive, duplex and node/repeater control
// Assumes: APB slave on clk_sys; system_reset_n is the device reset
// Notes: Strap pins are two-way: sampled, then driven as LEDs
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/100ps
`include "pslm_regs.vh"
module pslm_top #(
    parameter SAMPLE_CYC = `PSLM_SAMPLE_CYC,
    parameter STRETCH_CYC = `PSLM_STRETCH_CYC
) (
    clk_sys,
    system_reset_n,
    paddr,
    psel,
    penable,
    pwrite,
    pwdata,
    prdata,
    pready,
    pslverr,
    irq,
    strap_in,
    strap_out,
    strap_oe,
    duplex_pin_direction_strap,
    duplex_select_pin_in,
    duplex_select_pin_out,
    duplex_select_pin_oe,
    node_repeater_strap,
    link_ok_in,
    collision_in,
    rx_active_in,
    tx_active_in,
    rx_activity_in,
    link_ok_output,
    phy_addr,
    addr_valid,
    repeater_mode,
    sqe_test_en,
    crs_rx_only,
    full_duplex
);
    input wire clk_sys;
    input wire system_reset_n;
    input wire [11:0] paddr;
    input wire psel;
    input wire penable;
    input wire pwrite;
    input wire [31:0] pwdata;
    output reg [31:0] prdata;
    output wire pready;
    output wire pslverr;
    output wire irq;
    // Bit order: addr4_receive_led, addr3_transmit_led, addr2_link_led,
    // addr1_collision_led, addr0_full_duplex_led
    input wire [4:0] strap_in;
    output reg [4:0] strap_out;
    output reg [4:0] strap_oe;
    input wire duplex_pin_direction_strap;
    input wire duplex_select_pin_in;
    output reg duplex_select_pin_out;
    output reg duplex_select_pin_oe;
    input wire node_repeater_strap;
    input wire link_ok_in;
    input wire collision_in;
    input wire rx_active_in;
    input wire tx_active_in;
    input wire rx_activity_in;
    output reg link_ok_output;
    output reg [4:0] phy_addr;
    output reg addr_valid;
    output reg repeater_mode;
    output reg sqe_test_en;
    output reg crs_rx_only;
    output reg full_duplex;

    // ****************************************************************
    // Reset qualification and pin synchronisers
    // ****************************************************************
    localparam [7:0] RST_CYC = `PSLM_RST_MIN_CYC;
    localparam SCW = 32;

    // Reset pin low clears int_rst_n_r at once through its async reset, without waiting RST_CYC cycles,
    // and blk_rst_n also takes the raw pin, so even glitches under 80 ns reset the block.
    wire [9:0] pins_s;
    reg [7:0] rst_cnt_r;
    reg int_rst_n_r;

    pslm_sync #(
        .W(10)
    ) u_sync (
        .clk_sys(clk_sys),
        .rst_n(1'b1),
        .d({system_reset_n, node_repeater_strap, duplex_pin_direction_strap,
            duplex_select_pin_in, rx_active_in, tx_active_in, link_ok_in,
            collision_in, rx_activity_in, 1'b0}),
        .q(pins_s)
    );

    wire rst_pin_s = pins_s[9];
    wire nr_s = pins_s[8];
    wire dir_s = pins_s[7];
    wire dsel_s = pins_s[6];
    wire rxa_s = pins_s[5];
    wire txa_s = pins_s[4];
    wire link_s = pins_s[3];
    wire col_s = pins_s[2];
    wire rxact_s = pins_s[1];

    // Pin low clears the qualifier at once, so it never powers up unknown
    always @(posedge clk_sys or negedge system_reset_n) begin
        if (!system_reset_n) begin
            rst_cnt_r <= 8'h00;
            int_rst_n_r <= 1'b0;
        end else if (rst_pin_s) begin
            rst_cnt_r <= 8'h00;
            int_rst_n_r <= 1'b1;
        end else if (rst_cnt_r >= RST_CYC - 8'h01) begin
            int_rst_n_r <= 1'b0;
        end else begin
            rst_cnt_r <= rst_cnt_r + 8'h01;
        end
    end

    wire blk_rst_n = int_rst_n_r & system_reset_n;

    // ****************************************************************
    // Strap sampling state machine
    // ****************************************************************
    localparam ST_SETTLE = 3'b001;
    localparam ST_SAMPLE = 3'b010;
    localparam ST_RUN = 3'b100;

    reg [2:0] state_r;
    reg [SCW-1:0] cnt_r;
    reg [4:0] pol_r;
    reg [4:0] strap_q1_r;
    reg [4:0] strap_q2_r;
    reg dir_out_r;

    always @(posedge clk_sys or negedge blk_rst_n) begin
        if (!blk_rst_n) begin
            strap_q1_r <= 5'h00;
            strap_q2_r <= 5'h00;
        end else begin
            strap_q1_r <= strap_in;
            strap_q2_r <= strap_q1_r;
        end
    end

    always @(posedge clk_sys or negedge blk_rst_n) begin
        if (!blk_rst_n) begin
            state_r <= ST_SETTLE;
            cnt_r <= {SCW{1'b0}};
            phy_addr <= 5'h00;
            pol_r <= 5'h00;
            addr_valid <= 1'b0;
            repeater_mode <= 1'b0;
            dir_out_r <= 1'b0;
        end else begin
            case (state_r)
                ST_SETTLE: begin
                    if (cnt_r >= SAMPLE_CYC - 1) begin
                        state_r <= ST_SAMPLE;
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
                ST_SAMPLE: begin
                    // Bit weights 16/8/4/2/1 follow the bit order
                    phy_addr <= strap_q2_r;
                    pol_r <= strap_q2_r;
                    repeater_mode <= nr_s;
                    dir_out_r <= dir_s;
                    addr_valid <= 1'b1;
                    state_r <= ST_RUN;
                end
                ST_RUN: begin
                    state_r <= ST_RUN;
                end
                default: begin
                    state_r <= ST_SETTLE;
                end
            endcase
        end
    end

    wire running = state_r[2];

    // ****************************************************************
    // APB registers and interrupt
    // ****************************************************************
    reg [`PSLM_EV_W-1:0] status_r;
    reg [`PSLM_EV_W-1:0] mask_r;
    reg [2:0] cfg_r;
    reg link_d_r;
    reg full_d_r;
    reg col_d_r;

    wire wr_en = psel & penable & pwrite;
    wire rd_en = psel & ~pwrite;
    wire hit = (paddr == `PSLM_OFF_STATUS) | (paddr == `PSLM_OFF_MASK)
        | (paddr == `PSLM_OFF_CONFIG) | (paddr == `PSLM_OFF_STATE);

    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit;
    assign irq = |(status_r & mask_r);

    // Duplex selection: pin input when direction strap low, else config bit
    wire full_nxt = dir_out_r ? cfg_r[`PSLM_CFG_FULL_DUPLEX] : dsel_s;

    wire [`PSLM_EV_W-1:0] ev;
    assign ev[`PSLM_EV_LINK_UP] = running & link_s & ~link_d_r;
    assign ev[`PSLM_EV_LINK_DOWN] = running & ~link_s & link_d_r;
    assign ev[`PSLM_EV_COLL] = running & col_s & ~col_d_r;
    assign ev[`PSLM_EV_DUPLEX] = running & (full_duplex != full_d_r);

    wire [`PSLM_EV_W-1:0] clr = (wr_en && paddr == `PSLM_OFF_STATUS) ?
        pwdata[`PSLM_EV_W-1:0] : {`PSLM_EV_W{1'b0}};

    always @(posedge clk_sys or negedge blk_rst_n) begin
        if (!blk_rst_n) begin
            status_r <= {`PSLM_EV_W{1'b0}};
            mask_r <= {`PSLM_EV_W{1'b0}};
            cfg_r <= `PSLM_CFG_RESET;
            link_d_r <= 1'b0;
            col_d_r <= 1'b0;
            full_d_r <= 1'b0;
        end else begin
            // Set wins over a clear in the same cycle
            status_r <= (status_r & ~clr) | ev;
            link_d_r <= link_s;
            col_d_r <= col_s;
            full_d_r <= full_duplex;
            if (wr_en && paddr == `PSLM_OFF_MASK) begin
                mask_r <= pwdata[`PSLM_EV_W-1:0];
            end
            if (wr_en && paddr == `PSLM_OFF_CONFIG) begin
                cfg_r <= pwdata[2:0];
            end
        end
    end

    always @(posedge clk_sys or negedge blk_rst_n) begin
        if (!blk_rst_n) begin
            prdata <= 32'h00000000;
        end else if (rd_en && !penable) begin
            case (paddr)
                `PSLM_OFF_STATUS: prdata <= {28'h0000000, status_r};
                `PSLM_OFF_MASK: prdata <= {28'h0000000, mask_r};
                `PSLM_OFF_CONFIG: prdata <= {29'h00000000, cfg_r};
                `PSLM_OFF_STATE: prdata <= {16'h0000, pol_r, dir_out_r, sqe_test_en,
                    repeater_mode, link_ok_output, full_duplex, addr_valid, phy_addr};
                default: prdata <= 32'h00000000;
            endcase
        end
    end

    // ****************************************************************
    // Mode outputs, collision stretch and pin drive
    // ****************************************************************
    reg [SCW-1:0] str_cnt_r;
    wire col_lit = col_s | (str_cnt_r != {SCW{1'b0}});

    always @(posedge clk_sys or negedge blk_rst_n) begin
        if (!blk_rst_n) begin
            str_cnt_r <= {SCW{1'b0}};
        end else if (col_s) begin
            // Reloads on every collision, so a stream keeps it lit
            str_cnt_r <= STRETCH_CYC;
        end else if (str_cnt_r != {SCW{1'b0}}) begin
            str_cnt_r <= str_cnt_r - 1'b1;
        end
    end

    // A lit LED drives the pin opposite to its strap, pulling current
    // through the LED returned to the strap rail.
    function [0:0] led_drive;
        input on;
        input pol;
        begin
            led_drive = on ? ~pol : pol;
        end
    endfunction

    always @(posedge clk_sys or negedge blk_rst_n) begin
        if (!blk_rst_n) begin
            strap_out <= 5'h00;
            strap_oe <= 5'h00;
            duplex_select_pin_out <= 1'b0;
            duplex_select_pin_oe <= 1'b0;
            link_ok_output <= 1'b0;
            full_duplex <= 1'b0;
            sqe_test_en <= 1'b0;
            crs_rx_only <= 1'b0;
        end else if (running) begin
            full_duplex <= full_nxt;
            link_ok_output <= link_s;
            sqe_test_en <= cfg_r[`PSLM_CFG_SQE_OVR] ?
                cfg_r[`PSLM_CFG_SQE_OVR_VAL] : ~repeater_mode;
            crs_rx_only <= repeater_mode;
            duplex_select_pin_oe <= dir_out_r;
            duplex_select_pin_out <= dir_out_r & full_nxt;
            strap_oe <= 5'h1F;
            strap_out[4] <= led_drive(rxa_s, pol_r[4]);
            strap_out[3] <= led_drive(txa_s, pol_r[3]);
            strap_out[2] <= led_drive(link_s, pol_r[2]);
            strap_out[1] <= led_drive(col_lit, pol_r[1]);
            strap_out[0] <= led_drive(full_nxt, pol_r[0]);
        end
    end
endmodule // pslm_top

// *** sim/pslm_properties.sv ***
// Purpose: Port-level properties of the strap, LED and mode block
// Assumes: Sees only pslm_top ports; straps held steady by the board
// Notes: An LED pin drives the strap level, inverted while lit
`timescale 1ns/100ps
module pslm_properties (
    input wire clk_sys,
    input wire system_reset_n,
    input wire [4:0] strap_out,
    input wire [4:0] strap_oe,
    input wire [4:0] phy_addr,
    input wire addr_valid,
    input wire link_ok_in,
    input wire link_ok_output,
    input wire collision_in,
    input wire full_duplex,
    input wire duplex_pin_direction_strap,
    input wire duplex_select_pin_oe,
    input wire duplex_select_pin_out,
    input wire node_repeater_strap,
    input wire repeater_mode,
    input wire sqe_test_en,
    input wire crs_rx_only
);
    // ****
    // Properties
    // ****
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!system_reset_n);
    rst_quiet_a: assert property (disable iff (1'b0)
        !system_reset_n |-> !addr_valid && strap_oe == 5'h00) else $error("active in reset");
    link_track_a: assert property (addr_valid && $past(addr_valid, 3)
        |-> link_ok_output == $past(link_ok_in, 3)) else $error("link status lag");
    link_led_a: assert property (strap_oe[2] && $stable(link_ok_output)
        |-> strap_out[2] == (link_ok_output ^ phy_addr[2])) else $error("link led");
    fdx_led_a: assert property (strap_oe[0] && $stable(full_duplex)
        |-> strap_out[0] == (full_duplex ^ phy_addr[0])) else $error("duplex led");
    coll_led_a: assert property (addr_valid && $rose(collision_in)
        |-> ##[2:6] strap_out[1] ^ phy_addr[1]) else $error("collision led dark");
    addr_hold_a: assert property ($past(addr_valid) |-> addr_valid && $stable(phy_addr))
        else $error("address moved");
    led_mode_a: assert property (addr_valid && $past(addr_valid) |-> strap_oe == 5'h1F)
        else $error("led pins released");
    dir_in_a: assert property (addr_valid && $past(addr_valid)
        && !duplex_pin_direction_strap |-> !duplex_select_pin_oe) else $error("duplex pin driven");
    dir_out_a: assert property (addr_valid && $past(addr_valid) && duplex_pin_direction_strap
        |-> duplex_select_pin_oe && duplex_select_pin_out == full_duplex)
        else $error("dpx out");
    node_mode_a: assert property (addr_valid && $past(addr_valid)
        |-> repeater_mode == node_repeater_strap
        && sqe_test_en != node_repeater_strap && crs_rx_only == node_repeater_strap)
        else $error("node defaults");
endmodule // pslm_properties

// *** sim/pslm_board.sv ***
// Purpose: Board side: strap ties through LEDs on the two-way pins
// Assumes: Each strap pin hangs on an LED to one rail
// Notes: An undriven pin floats to the rail its LED goes to
`timescale 1ns/100ps
module pslm_board (
    input wire [4:0] strap_tie,
    input wire [4:0] strap_out,
    input wire [4:0] strap_oe,
    input wire dpx_tie,
    input wire duplex_select_pin_out,
    input wire duplex_select_pin_oe,
    output logic [4:0] strap_in,
    output logic duplex_select_pin_in,
    output logic [4:0] led_lit
);
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            strap_in[i] = strap_oe[i] ? strap_out[i] : strap_tie[i];
            led_lit[i] = strap_oe[i] && (strap_out[i] != strap_tie[i]);
        end
        duplex_select_pin_in = duplex_select_pin_oe ? duplex_select_pin_out : dpx_tie;
    end
endmodule // pslm_board

// *** sim/pslm_top_tb.sv ***
// Purpose: Self-checking bench for the strap, LED and mode block
// Assumes: Short sample and stretch counts
// Notes: Straps only change while reset is held
`timescale 1ns/100ps
`include "pslm_regs.vh"
module pslm_top_tb;
    localparam int STR = 16;
    logic clk_sys, system_reset_n, psel, penable, pwrite, pready, pslverr, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [4:0] strap_in, strap_out, strap_oe, phy_addr, strap_tie, led_lit;
    logic duplex_pin_direction_strap, duplex_select_pin_in, duplex_select_pin_out;
    logic duplex_select_pin_oe, node_repeater_strap, link_ok_in, collision_in, dpx_tie;
    logic rx_active_in, tx_active_in, rx_activity_in, link_ok_output, addr_valid;
    logic repeater_mode, sqe_test_en, crs_rx_only, full_duplex, e;
    int failures = 0, num_checks = 0, cyc = 0;
    pslm_top #(.SAMPLE_CYC(4), .STRETCH_CYC(STR)) uut (.clk_sys, .system_reset_n,
        .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .irq,
        .strap_in, .strap_out, .strap_oe, .duplex_pin_direction_strap,
        .duplex_select_pin_in, .duplex_select_pin_out, .duplex_select_pin_oe,
        .node_repeater_strap, .link_ok_in, .collision_in, .rx_active_in, .tx_active_in,
        .rx_activity_in, .link_ok_output, .phy_addr, .addr_valid, .repeater_mode,
        .sqe_test_en, .crs_rx_only, .full_duplex);
    pslm_board brd (.strap_tie, .strap_out, .strap_oe, .dpx_tie, .duplex_select_pin_out,
        .duplex_select_pin_oe, .strap_in, .duplex_select_pin_in, .led_lit);
    // ****
    // Helpers
    // ****
    task report_and_stop;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] x);
        num_checks++;
        if (g !== x) begin
            failures++;
            $display("Error t=%0t got %h exp %h", $time, g, x);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Straps move only while reset is held, as the board would see it
    task do_reset(input logic [4:0] tie, input logic nr, input logic dir);
        int n;
        n = 0;
        @(posedge clk_sys);
        system_reset_n <= 1'b0;
        @(posedge clk_sys);
        strap_tie <= tie;
        node_repeater_strap <= nr;
        duplex_pin_direction_strap <= dir;
        repeat (24) @(posedge clk_sys);
        system_reset_n <= 1'b1;
        while (addr_valid !== 1'b1 && n < 300) begin
            @(posedge clk_sys);
            n++;
        end
        repeat (2) @(posedge clk_sys);
        chk(addr_valid, 1);
    endtask
    // ****
    // Scenarios
    // ****
    task t_straps;
        logic [4:0] v [6] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h0A};
        for (int i = 0; i < 6; i++) begin
            do_reset(v[i], i[0], duplex_pin_direction_strap);
            chk(phy_addr, v[i]);
            chk({repeater_mode, sqe_test_en, crs_rx_only}, {i[0], !i[0], i[0]});
            chk(led_lit, 5'h00);
        end
    endtask
    task t_link;
        link_ok_in <= 1'b1;
        repeat (6) @(posedge clk_sys);
        chk({link_ok_output, led_lit[2]}, 2'h3);
        link_ok_in <= 1'b0;
        repeat (6) @(posedge clk_sys);
        chk({link_ok_output, led_lit[2]}, 2'h0);
    endtask
    task t_coll;
        collision_in <= 1'b1;
        @(posedge clk_sys);
        collision_in <= 1'b0;
        repeat (STR) @(posedge clk_sys);
        chk(led_lit[1], 1);
        repeat (STR + 20) @(posedge clk_sys);
        chk(led_lit[1], 0);
        collision_in <= 1'b1;
        repeat (STR * 4) @(posedge clk_sys);
        chk(led_lit[1], 1);
        collision_in <= 1'b0;
    endtask
    task t_duplex;
        dpx_tie <= 1'b1;
        do_reset(strap_tie, node_repeater_strap, 1'b0);
        chk({full_duplex, duplex_select_pin_oe, led_lit[0]}, 3'h5);
        dpx_tie <= 1'b0;
        repeat (6) @(posedge clk_sys);
        chk(full_duplex, 0);
        do_reset(strap_tie, node_repeater_strap, 1'b1);
        chk({duplex_select_pin_oe, duplex_select_pin_out}, 2'h2);
        apb(1'b1, `PSLM_OFF_CONFIG, 32'h00000001);
        repeat (6) @(posedge clk_sys);
        chk({duplex_select_pin_out, led_lit[0]}, 2'h3);
        do_reset(strap_tie, node_repeater_strap, 1'b1);
        chk(full_duplex, 0);
    endtask
    task t_irq;
        apb(1'b1, `PSLM_OFF_MASK, 32'h00000001);
        link_ok_in <= 1'b1;
        repeat (6) @(posedge clk_sys);
        chk(irq, 1);
        apb(1'b0, `PSLM_OFF_STATUS, 32'h0);
        chk(q, 32'h00000001);
        apb(1'b1, `PSLM_OFF_MASK, 32'h00000000);
        @(posedge clk_sys);
        chk(irq, 0);
        apb(1'b1, `PSLM_OFF_MASK, 32'h00000001);
        apb(1'b1, `PSLM_OFF_STATUS, 32'h00000001);
        @(posedge clk_sys);
        chk(irq, 0);
        apb(1'b0, `PSLM_OFF_STATE, 32'h0);
        chk(q[5:0], {1'b1, strap_tie});
        apb(1'b0, 12'h010, 32'h0);
        chk({31'h00000000, e}, 32'h00000001);
        chk(q, 32'h00000000);
        link_ok_in <= 1'b0;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            report_and_stop();
        end
    end
    initial begin
        {system_reset_n, psel, penable, pwrite, paddr, pwdata} = '0;
        {strap_tie, dpx_tie, duplex_pin_direction_strap, node_repeater_strap} = '0;
        {link_ok_in, collision_in, rx_active_in, tx_active_in, rx_activity_in} = '0;
        repeat (20) @(posedge clk_sys);
        system_reset_n <= 1'b1;
        t_straps();
        t_link();
        t_coll();
        t_duplex();
        t_irq();
        report_and_stop();
    end
endmodule // pslm_top_tb
bind pslm_top pslm_properties chk_i (.clk_sys, .system_reset_n, .strap_out, .strap_oe,
    .phy_addr, .addr_valid, .link_ok_in, .link_ok_output, .collision_in, .full_duplex,
    .duplex_pin_direction_strap, .duplex_select_pin_oe, .duplex_select_pin_out,
    .node_repeater_strap, .repeater_mode, .sqe_test_en, .crs_rx_only);
